//--- dotc_pkg.sv
// dotc_pkg: constants, types and helpers of the termination control block.
// assumes one 20 MHz clock domain; used as dotc_pkg::name everywhere.
package dotc_pkg;

  // register offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_LAT  = 8'h08;

  // control field positions
  localparam int CTRL_RTT_NOM_LSB = 0;
  localparam int CTRL_TERM_DATA_STROBE_BIT    = 3;
  localparam int CTRL_RTT_WR_LSB  = 4;
  localparam int CTRL_DLL_PD_BIT  = 6;
  localparam int CTRL_CWL_LSB     = 8;
  localparam int CTRL_AL_LSB      = 12;

  // status field positions
  localparam int STAT_TERM_BIT = 0;
  localparam int STAT_TERM_DATA_STROBE_BIT = 1;
  localparam int STAT_MODE_LSB = 4;
  localparam int STAT_VIOL_BIT = 8;
  localparam int STAT_PIN_BIT  = 9;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0500;

  // timing counts in clock cycles
  localparam logic [2:0] TERM_HOLD_SHORT = 3'h4;
  localparam logic [2:0] TERM_HOLD_LONG  = 3'h6;
  localparam logic [5:0] LAT_OFFSET      = 6'h02;
  localparam int         DELAY_DEPTH     = 32;
  localparam logic [5:0] LAT_MAX         = 6'h20;
  localparam logic [5:0] LAT_MIN         = 6'h01;

  typedef enum logic [3:0] {
    DOTC_SELF_REFRESH = 4'h1,
    DOTC_SYNC         = 4'h2,
    DOTC_ASYNC        = 4'h4,
    DOTC_DLL_OFF      = 4'h8
  } dotc_mode_t;

  typedef struct packed {
    logic [4:0] additive_latency;
    logic [3:0] write_cas_latency;
    logic       dll_pd_keep;
    logic [1:0] rtt_wr;
    logic       term_data_strobe_en;
    logic [2:0] rtt_nom;
  } dotc_cfg_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dotc_bus_t;

  typedef struct packed {
    logic self_refresh;
    logic dll_on;
    logic dll_locked;
    logic clock_enable_pin;
    logic precharge_pd;
  } dotc_dram_state_t;

  // turn-on/turn-off latency, clamped to the delay line
  function automatic logic [5:0] term_latency(input dotc_cfg_t cfg);
    logic [5:0] sum;
    sum = {2'h0, cfg.write_cas_latency} + {1'b0, cfg.additive_latency};
    if (sum <= LAT_OFFSET)
    begin
      return LAT_MIN;
    end
    sum = sum - LAT_OFFSET;
    if (sum > LAT_MAX)
    begin
      return LAT_MAX;
    end
    return sum;
  endfunction : term_latency

endpackage : dotc_pkg

//--- dotc_delay_line.sv
// dotc_delay_line: shift line of sampled pin values with a selectable tap.
// assumes tap in 1..DELAY_DEPTH; tap k gives the sample taken k edges ago.
`timescale 1ns/1ps
module dotc_delay_line (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       din,
  input  wire logic [5:0] tap,
  output logic            dout
);

  typedef struct packed {
    logic [dotc_pkg::DELAY_DEPTH-1:0] line;
  } dotc_dl_state_t;

  dotc_dl_state_t st;
  dotc_dl_state_t next_st;

  always_comb
  begin
    next_st      = st;
    next_st.line = {st.line[dotc_pkg::DELAY_DEPTH-2:0], din};
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

  assign dout = st.line[5'(tap - 6'h01)];

endmodule : dotc_delay_line

//--- dotc_hold_check.sv
// dotc_hold_check: watches the minimum high time of the termination pin.
// assumes pin and write strobe are sampled on the same rising edge.
`timescale 1ns/1ps
module dotc_hold_check (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic pin,
  input  wire logic write_cmd,
  input  wire logic burst_chop4,
  output logic      violation
);

  typedef struct packed {
    logic       prev;
    logic [2:0] remain;
  } dotc_hc_state_t;

  dotc_hc_state_t st;
  dotc_hc_state_t next_st;
  logic [2:0]     need;

  always_comb
  begin
    next_st = st;
    need    = burst_chop4 ? dotc_pkg::TERM_HOLD_SHORT : dotc_pkg::TERM_HOLD_LONG;
    next_st.prev = pin;
    if (pin)
    begin
      if (st.remain != 3'h0)
      begin
        next_st.remain = st.remain - 3'h1;
      end
      if (!st.prev && (next_st.remain < dotc_pkg::TERM_HOLD_SHORT - 3'h1))
      begin
        next_st.remain = dotc_pkg::TERM_HOLD_SHORT - 3'h1;
      end
      if (write_cmd && (next_st.remain < need - 3'h1))
      begin
        next_st.remain = need - 3'h1;
      end
    end
    else
    begin
      next_st.remain = 3'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

  // low registered while hold still running
  assign violation = ce && !pin && (st.remain != 3'h0);

endmodule : dotc_hold_check

//--- dotc_top.sv
// dotc_top: device-side on-die termination control with a small register port.
// assumes all pins synchronous to ref_clk; read data valid one cycle after rd.
//
// Function
// - the termination pin switches termination of data, strobe and mask lines, and the extra strobe pair only when its enable bit is set.
// - in self-refresh termination stays off and the pin is ignored.
// - termination is enabled when any nominal- or write-resistance bit is set, and the nominal bits pick the resistance.
// - pin low means off, pin high means on unless the mode settings disable termination.
// - switching never looks at read or write command decode.
// - synchronous timing applies while the delay loop is on and locked, including active and loop-kept precharge power-down.
// - in synchronous mode termination turns on and off a fixed latency after the pin is sampled.
// - both latencies equal write cas latency plus additive latency minus two.
// - in synchronous mode the internal control lags the pin by write cas latency plus additive latency minus two.
// - after a read termination returns when the device stops driving the data outputs.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module dotc_top (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic                        ce,
  input  wire dotc_pkg::dotc_bus_t         bus,
  output logic [31:0]                      rd_data,
  input  wire logic                        termination_ctrl_pin,
  input  wire dotc_pkg::dotc_dram_state_t  dram_state,
  input  wire logic                        write_cmd,
  input  wire logic                        burst_chop4,
  input  wire logic                        data_drive,
  output logic                             term_dq_en,
  output logic                             term_term_data_strobe_en,
  output logic [2:0]                       termination_resistance
);

  typedef struct packed {
    dotc_pkg::dotc_cfg_t  cfg;
    dotc_pkg::dotc_mode_t mode;
    logic                 term;
    logic                 term_data_strobe_term;
    logic [2:0]           rtt;
    logic                 viol;
    logic [31:0]          rd_data;
  } dotc_top_state_t;

  dotc_top_state_t      st;
  dotc_top_state_t      next_st;
  dotc_pkg::dotc_mode_t next_mode;
  logic [5:0]           latency;
  logic                 line_in;
  logic                 line_out;
  logic                 hold_viol;
  logic                 enabled;
  logic                 want;
  logic                 loop_ok;
  logic                 wr_ctrl;
  logic                 wr_stat;
  logic [31:0]          ctrl_word;
  logic [31:0]          stat_word;

  // control word to settings, shared by register writes and reset
  function automatic dotc_pkg::dotc_cfg_t cfg_of(input logic [31:0] w);
    dotc_pkg::dotc_cfg_t c;
    c.rtt_nom           = w[dotc_pkg::CTRL_RTT_NOM_LSB +: 3];
    c.term_data_strobe_en           = w[dotc_pkg::CTRL_TERM_DATA_STROBE_BIT];
    c.rtt_wr            = w[dotc_pkg::CTRL_RTT_WR_LSB +: 2];
    c.dll_pd_keep       = w[dotc_pkg::CTRL_DLL_PD_BIT];
    c.write_cas_latency = w[dotc_pkg::CTRL_CWL_LSB +: 4];
    c.additive_latency  = w[dotc_pkg::CTRL_AL_LSB +: 5];
    return c;
  endfunction : cfg_of

  // control word skips bit 7, so a plain cast of the word to the settings would misplace fields
  localparam dotc_pkg::dotc_cfg_t CFG_RESET = cfg_of(dotc_pkg::CTRL_RESET);

  // latency from mode settings, shared by line and readback
  assign latency = dotc_pkg::term_latency(st.cfg);

  // pin is blanked in self-refresh so the line holds no stale highs
  assign line_in = termination_ctrl_pin && (st.mode != dotc_pkg::DOTC_SELF_REFRESH);

  dotc_delay_line u_line (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .din     (line_in),
    .tap     (latency),
    .dout    (line_out)
  );

  dotc_hold_check u_hold (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .ce          (ce),
    .pin         (termination_ctrl_pin),
    .write_cmd   (write_cmd),
    .burst_chop4 (burst_chop4),
    .violation   (hold_viol)
  );

  assign wr_ctrl = bus.wr && (bus.addr == dotc_pkg::ADDR_CTRL);
  assign wr_stat = bus.wr && (bus.addr == dotc_pkg::ADDR_STAT);

  always_comb
  begin
    ctrl_word = '0;
    ctrl_word[dotc_pkg::CTRL_RTT_NOM_LSB +: 3] = st.cfg.rtt_nom;
    ctrl_word[dotc_pkg::CTRL_TERM_DATA_STROBE_BIT]         = st.cfg.term_data_strobe_en;
    ctrl_word[dotc_pkg::CTRL_RTT_WR_LSB +: 2]  = st.cfg.rtt_wr;
    ctrl_word[dotc_pkg::CTRL_DLL_PD_BIT]       = st.cfg.dll_pd_keep;
    ctrl_word[dotc_pkg::CTRL_CWL_LSB +: 4]     = st.cfg.write_cas_latency;
    ctrl_word[dotc_pkg::CTRL_AL_LSB +: 5]      = st.cfg.additive_latency;
  end

  always_comb
  begin
    stat_word = '0;
    stat_word[dotc_pkg::STAT_TERM_BIT]      = st.term;
    stat_word[dotc_pkg::STAT_TERM_DATA_STROBE_BIT]      = st.term_data_strobe_term;
    stat_word[dotc_pkg::STAT_MODE_LSB +: 4] = st.mode;
    stat_word[dotc_pkg::STAT_VIOL_BIT]      = st.viol;
    stat_word[dotc_pkg::STAT_PIN_BIT]       = termination_ctrl_pin;
  end

  // timing mode from loop and power-down state
  assign loop_ok = dram_state.dll_on && dram_state.dll_locked;

  always_comb
  begin
    if (dram_state.self_refresh)
    begin
      next_mode = dotc_pkg::DOTC_SELF_REFRESH;
    end
    else if (!loop_ok)
    begin
      next_mode = dotc_pkg::DOTC_DLL_OFF;
    end
    else if (!dram_state.clock_enable_pin && dram_state.precharge_pd
             && !st.cfg.dll_pd_keep)
    begin
      next_mode = dotc_pkg::DOTC_ASYNC;
    end
    else
    begin
      next_mode = dotc_pkg::DOTC_SYNC;
    end
  end

  // either nominal or write resistance set keeps termination usable
  assign enabled = (st.cfg.rtt_nom != 3'h0) || (st.cfg.rtt_wr != 2'h0);

  // pin decides, never command decode
  always_comb
  begin
    unique case (st.mode)
      dotc_pkg::DOTC_SELF_REFRESH:
      begin
        want = 1'b0;
      end
      dotc_pkg::DOTC_SYNC:
      begin
        want = line_out;
      end
      dotc_pkg::DOTC_ASYNC:
      begin
        want = termination_ctrl_pin;
      end
      dotc_pkg::DOTC_DLL_OFF:
      begin
        want = termination_ctrl_pin;
      end
      default:
      begin
        want = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    next_st      = st;
    next_st.mode = next_mode;

    if (wr_ctrl)
    begin
      next_st.cfg = cfg_of(bus.wdata);
    end

    // sticky hold flag: write one to clear, a new event wins
    if (wr_stat && bus.wdata[dotc_pkg::STAT_VIOL_BIT])
    begin
      next_st.viol = 1'b0;
    end
    // pin is disregarded in self-refresh, hold checks included
    if (hold_viol && (st.mode != dotc_pkg::DOTC_SELF_REFRESH))
    begin
      next_st.viol = 1'b1;
    end

    // off while the device drives reads; back on as soon as it stops
    next_st.term = want && enabled && !data_drive;
    next_st.term_data_strobe_term = next_st.term && st.cfg.term_data_strobe_en;
    next_st.rtt  = st.cfg.rtt_nom;

    next_st.rd_data = '0;
    if (bus.rd)
    begin
      unique case (bus.addr)
        dotc_pkg::ADDR_CTRL:
        begin
          next_st.rd_data = ctrl_word;
        end
        dotc_pkg::ADDR_STAT:
        begin
          next_st.rd_data = stat_word;
        end
        dotc_pkg::ADDR_LAT:
        begin
          next_st.rd_data = {26'h0, latency};
        end
        default:
        begin
          next_st.rd_data = '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st           <= '0;
      st.cfg       <= CFG_RESET;
      st.mode      <= dotc_pkg::DOTC_DLL_OFF;
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

  assign rd_data                = st.rd_data;
  assign term_dq_en             = st.term;
  assign term_term_data_strobe_en           = st.term_data_strobe_term;
  assign termination_resistance = st.rtt;

endmodule : dotc_top

//--- dotc_properties.sv
// dotc_properties: timing checks on the termination control ports.
// assumes ce held high; bound into dotc_top below.
`timescale 1ns/1ps
module dotc_properties (
  input wire logic                       ref_clk,
  input wire logic                       rst_n,
  input wire logic                       ce,
  input wire dotc_pkg::dotc_bus_t        bus,
  input wire logic [31:0]                rd_data,
  input wire logic                       termination_ctrl_pin,
  input wire dotc_pkg::dotc_dram_state_t dram_state,
  input wire logic                       write_cmd,
  input wire logic                       burst_chop4,
  input wire logic                       data_drive,
  input wire logic                       term_dq_en,
  input wire logic                       term_term_data_strobe_en,
  input wire logic [2:0]                 termination_resistance
);
  logic [31:0] cfg;
  logic [32:0] hist;
  logic [5:0]  stb;
  logic [5:0]  sum;
  logic        en;
  logic        sync;
  logic        cw;
  assign sum  = {2'h0, cfg[11:8]} + {1'b0, cfg[16:12]};
  assign en   = (cfg[2:0] != 3'h0) || (cfg[5:4] != 2'h0);
  assign cw   = bus.wr && (bus.addr == dotc_pkg::ADDR_CTRL);
  assign sync = dram_state.dll_on && dram_state.dll_locked && !dram_state.self_refresh
                && (!dram_state.precharge_pd || cfg[6]);
  // shadow of the control word and of past pin samples
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg  <= dotc_pkg::CTRL_RESET;
      hist <= '0;
      stb  <= '0;
    end
    else if (ce)
    begin
      if (cw)
      begin
        cfg <= bus.wdata;
      end
      hist <= {hist[31:0], termination_ctrl_pin};
      stb  <= (sync && en && !data_drive && !cw && sum > 6'h02 && sum < 6'h23)
              ? stb + {5'h00, stb != 6'h3f} : 6'h00;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_sr_held; dram_state.self_refresh [*3]; endsequence
  sequence s_driving; data_drive ##1 data_drive; endsequence
  property p_sr; s_sr_held |-> !term_dq_en && !term_term_data_strobe_en; endproperty
  property p_low; hist == 33'h0 |-> !term_dq_en; endproperty
  property p_dis; (!en) [*3] |-> !term_dq_en; endproperty
  property p_term_data_strobe; term_term_data_strobe_en |-> term_dq_en && $past(cfg[3]); endproperty
  property p_drive; s_driving |-> !term_dq_en && !term_term_data_strobe_en; endproperty
  property p_res; $stable(cfg) [*2] |-> termination_resistance == cfg[2:0]; endproperty
  property p_lat; stb > 6'h28 |-> term_dq_en == hist[sum - 6'h02]; endproperty
  property p_rd_idle; !bus.rd |=> rd_data == 32'h0000_0000; endproperty
  a_sr: assert property (p_sr) else $error("term on in self-refresh");
  a_low: assert property (p_low) else $error("term on with pin low");
  a_dis: assert property (p_dis) else $error("term on while disabled");
  a_term_data_strobe: assert property (p_term_data_strobe) else $error("strobe pair term wrong");
  a_drive: assert property (p_drive) else $error("term on while driving");
  a_res: assert property (p_res) else $error("resistance mismatch");
  a_lat: assert property (p_lat) else $error("term latency wrong");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
endmodule : dotc_properties

bind dotc_top dotc_properties dotc_properties_i (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
  .bus(bus), .rd_data(rd_data), .termination_ctrl_pin(termination_ctrl_pin),
  .dram_state(dram_state), .write_cmd(write_cmd), .burst_chop4(burst_chop4),
  .data_drive(data_drive), .term_dq_en(term_dq_en), .term_term_data_strobe_en(term_term_data_strobe_en),
  .termination_resistance(termination_resistance));

//--- dotc_ctrl_model.sv
// dotc_ctrl_model: controller side of the termination pin.
// assumes go is one cycle; brk drops the hold limits on purpose.
`timescale 1ns/1ps
module dotc_ctrl_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       dll_on,
  input  wire logic       go,
  input  wire logic [3:0] len,
  input  wire logic [3:0] wr_at,
  input  wire logic       bc4,
  input  wire logic       brk,
  output logic            pin,
  output logic            write_cmd,
  output logic            burst_chop4
);
  logic [3:0] el;
  logic [3:0] need;
  logic [3:0] wh;
  always_comb
  begin
    wh   = (wr_at != 4'h0) ? wr_at + (bc4 ? 4'h4 : 4'h6) : 4'h0;
    need = (len > 4'h4) ? len : 4'h4;
    need = (wh > need) ? wh : need;
    need = brk ? len : need;
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      el          <= 4'h0;
      pin         <= 1'b0;
      write_cmd   <= 1'b0;
      burst_chop4 <= 1'b0;
    end
    else if (go && dll_on)
    begin
      pin <= 1'b1;
      el  <= 4'h1;
    end
    else if (pin)
    begin
      el          <= el + 4'h1;
      pin         <= (el != need);
      write_cmd   <= (el == wr_at);
      burst_chop4 <= bc4;
    end
    else
    begin
      write_cmd <= 1'b0;
    end
  end
endmodule : dotc_ctrl_model

//--- tb_dotc_top.sv
// tb_dotc_top: register and pin scenarios for the termination block.
// assumes dotc_ctrl_model drives the pin side; checker is bound.
`timescale 1ns/1ps
module tb_dotc_top;
  logic                       ref_clk;
  logic                       rst_n;
  logic                       ce;
  dotc_pkg::dotc_bus_t        bus;
  logic [31:0]                rd_data;
  logic                       pin;
  dotc_pkg::dotc_dram_state_t ds;
  logic                       wcmd;
  logic                       bc4o;
  logic                       data_drive;
  logic                       term;
  logic                       term_data_strobe;
  logic [2:0]                 res;
  logic                       go;
  logic [3:0]                 len;
  logic [3:0]                 wat;
  logic                       bc4;
  logic                       brk;
  int                         bad_count;
  int                         checks_done;
  logic [8:0]                 cl [4] = '{9'h005, 9'h046, 9'h001, 9'h1ff};
  logic [5:0]                 lx [4] = '{6'h03, 6'h08, 6'h01, 6'h20};
  logic [3:0]                 hl [5] = '{4'h1, 4'h5, 4'h6, 4'h3, 4'h4};
  logic [3:0]                 hw [5] = '{4'h3, 4'h2, 4'h2, 4'h0, 4'h0};
  logic [4:0]                 hb = 5'h04;
  logic [4:0]                 hk = 5'h1e;
  logic [4:0]                 hv = 5'h0a;
  dotc_top dotc_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .bus(bus),
    .rd_data(rd_data), .termination_ctrl_pin(pin), .dram_state(ds), .write_cmd(wcmd),
    .burst_chop4(bc4o), .data_drive(data_drive), .term_dq_en(term), .term_term_data_strobe_en(term_data_strobe),
    .termination_resistance(res));
  dotc_ctrl_model dotc_ctrl_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .dll_on(ds.dll_on),
    .go(go), .len(len), .wr_at(wat), .bc4(bc4), .brk(brk), .pin(pin), .write_cmd(wcmd),
    .burst_chop4(bc4o));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1;
    chk(rd_data, exp, nm);
    @(posedge ref_clk);
  endtask : rd
  task automatic pulse(input logic [3:0] l, input logic [3:0] w, input logic b, input logic k);
    len <= l;
    wat <= w;
    bc4 <= b;
    brk <= k;
    go  <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
  endtask : pulse
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic settle;
    #1;
    for (int i = 0; i < 60 && pin; i++) @(posedge ref_clk);
    repeat (40) @(posedge ref_clk);
  endtask : settle
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    finish_test();
  end
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    bus = '0;
    ds = '0;
    data_drive = 1'b0;
    go = 1'b0;
    len = 4'h0;
    wat = 4'h0;
    bc4 = 1'b0;
    brk = 1'b0;
    bad_count = 0;
    checks_done = 0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(dotc_pkg::ADDR_CTRL, dotc_pkg::CTRL_RESET, "ctrl reset");
    rd(dotc_pkg::ADDR_STAT, 32'h0000_0080, "stat reset");
    for (int i = 0; i < 4; i++)
    begin
      wr(dotc_pkg::ADDR_CTRL, {15'h0000, cl[i], 8'h00});
      rd(dotc_pkg::ADDR_LAT, {26'h0000_000, lx[i]}, "latency");
    end
    ds <= 5'h0e;
    for (int a = 0; a < 2; a++)
    begin
      wr(dotc_pkg::ADDR_CTRL, (a == 1) ? 32'h0000_2509 : 32'h0000_0509);
      rd(dotc_pkg::ADDR_STAT, 32'h0000_0020, "sync mode");
      pulse(4'h6, 4'h0, 1'b0, 1'b0);
      tick((a == 1) ? 5 : 3);
      chk({31'h0, term}, 32'h0, "term early");
      tick(1);
      chk({30'h0, term_data_strobe, term}, 32'h3, "term on");
      chk({29'h0, res}, 32'h1, "resistance");
      settle();
    end
    for (int i = 0; i < 5; i++)
    begin
      pulse(hl[i], hw[i], hb[i], hk[i]);
      settle();
      rd(dotc_pkg::ADDR_STAT, {23'h0, hv[i], 8'h20}, "hold flag");
      wr(dotc_pkg::ADDR_STAT, 32'h0000_0100);
    end
    rd(8'h0c, 32'h0000_0000, "unmapped");
    pulse(4'h9, 4'h0, 1'b0, 1'b0);
    repeat (7) @(posedge ref_clk);
    data_drive <= 1'b1;
    tick(2);
    chk({31'h0, term}, 32'h0, "drive off");
    @(posedge ref_clk);
    data_drive <= 1'b0;
    tick(2);
    chk({31'h0, term}, 32'h1, "drive over");
    settle();
    // controller drops the pin early, read drives, pin raised again after
    pulse(4'h4, 4'h0, 1'b0, 1'b0);
    tick(10);
    chk({31'h0, term}, 32'h0, "off before read");
    @(posedge ref_clk);
    data_drive <= 1'b1;
    tick(2);
    chk({31'h0, term}, 32'h0, "read driving");
    @(posedge ref_clk);
    data_drive <= 1'b0;
    pulse(4'h4, 4'h0, 1'b0, 1'b0);
    tick(5);
    chk({31'h0, term}, 32'h0, "after read early");
    tick(1);
    chk({31'h0, term}, 32'h1, "after read on");
    settle();
    ds <= 5'h1e;
    @(posedge ref_clk);
    rd(dotc_pkg::ADDR_STAT, 32'h0000_0010, "self refresh");
    pulse(4'h9, 4'h0, 1'b0, 1'b0);
    tick(8);
    chk({31'h0, term}, 32'h0, "self refresh off");
    settle();
    ds <= 5'h0d;
    @(posedge ref_clk);
    rd(dotc_pkg::ADDR_STAT, 32'h0000_0040, "pd frozen");
    wr(dotc_pkg::ADDR_CTRL, 32'h0000_2540);
    @(posedge ref_clk);
    rd(dotc_pkg::ADDR_STAT, 32'h0000_0020, "pd kept");
    pulse(4'h9, 4'h0, 1'b0, 1'b0);
    tick(8);
    chk({31'h0, term}, 32'h0, "disabled");
    settle();
    finish_test();
  end
endmodule : tb_dotc_top
